// ---- bench/clock_sink_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Consumer side of one divided clock: measures phases in clk cycles.
// Only whole phases are summed; the one cut by clear is dropped.
module clock_sink_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clear,
    input  wire logic        clk_in,
    output logic      [31:0] toggles,
    output logic      [31:0] high_sum,
    output logic      [31:0] low_sum,
    output logic      [31:0] min_phase
);
    logic        last;
    logic        seen;
    logic [31:0] run;

    always @(posedge clk) begin
        if (!reset_n || clear) begin
            toggles   <= 32'h0;
            high_sum  <= 32'h0;
            low_sum   <= 32'h0;
            min_phase <= 32'hFFFFFFFF;
            run       <= 32'h0;
            seen      <= 1'b0;
        end else if (clk_in != last) begin
            toggles <= toggles + 32'h1;
            seen    <= 1'b1;
            run     <= 32'h0;
            if (seen) begin
                if (last)
                    high_sum <= high_sum + run + 32'h1;
                else
                    low_sum <= low_sum + run + 32'h1;
                if (run + 32'h1 < min_phase)
                    min_phase <= run + 32'h1;
            end
        end else begin
            run <= run + 32'h1;
        end
        last <= clk_in;
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
module testbench;
    import clk_reset_pkg::*;
    localparam int SPAN = 16000;
    // Two sync flops plus edge detect before the pulse output rises
    localparam int TRIG_LAT = 3;
    logic clk = 1'b0, reset_n = 1'b0, speed_fast = 1'b0, trig_n = 1'b0;
    logic ben_n = 1'b1, bdir_n = 1'b1, clear = 1'b0;
    logic video, baud, cpu, rst, rst_n, aen_n, den_n, ddir_n;
    logic [2:0]  mclk;
    logic [31:0] tog [3];
    logic [31:0] hi [3];
    logic [31:0] lo [3];
    logic [31:0] mn [3];
    int n_errors = 0, cmp_count = 0, addr_bad = 0;

    always #10 clk = ~clk;
    assign mclk = {cpu, baud, video};

    system_clock_reset_gen uut (
        .clk(clk), .reset_n(reset_n), .speed_fast(speed_fast),
        .reset_trigger_n(trig_n), .buf_enable_req_n(ben_n),
        .buf_dir_req_n(bdir_n), .video_ref_clock(video),
        .serial_baud_ref_clock(baud), .cpu_clock(cpu),
        .sys_reset(rst), .sys_reset_n(rst_n),
        .addr_buffer_enable_n(aen_n), .data_buffer_enable_n(den_n),
        .data_buffer_dir_n(ddir_n));

    for (genvar g = 0; g < 3; g++) begin : meter
        clock_sink_model sink (
            .clk(clk), .reset_n(reset_n), .clear(clear),
            .clk_in(mclk[g]), .toggles(tog[g]), .high_sum(hi[g]),
            .low_sum(lo[g]), .min_phase(mn[g]));
    end

    always @(negedge clk) if (reset_n && aen_n !== 1'b0) addr_bad++;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic window(input int span);
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        repeat (span) @(negedge clk);
    endtask

    task automatic judge(input int idx, input int half);
        longint e, d, s;
        e = longint'(SPAN) * 2 * MASTER_OSC_HZ / (longint'(CLK_HZ) * half);
        d = longint'(tog[idx]) - e;
        s = longint'(hi[idx]) - longint'(lo[idx]);
        `CHECK((d <= 2 && d >= -2), 1'b1)
        `CHECK((s <= 2 * half + 2 && s >= -2 * half - 2), 1'b1)
    endtask

    // Power hold keeps reset quiet, then one full pulse on both outputs
    task automatic test_power_up();
        int bad, lead, width;
        bad = 0;
        repeat (50) begin
            @(negedge clk);
            if (rst !== 1'b0 || rst_n !== 1'b1) bad++;
        end
        `CHECK(bad, 0)
        trig_n = 1'b1;
        lead = 0;
        while (rst !== 1'b1 && lead < 20) begin
            @(negedge clk);
            lead++;
        end
        width = 0;
        while (rst === 1'b1 && width < 10000) begin
            if (rst_n !== 1'b0) bad++;
            width++;
            @(negedge clk);
        end
        `CHECK(lead, TRIG_LAT)
        `CHECK(width, RESET_PULSE_CYCLES)
        `CHECK(bad, 0)
        $display("test_power_up done");
    endtask

    // Press mid-pulse must not end it; release restarts the full width
    task automatic test_retrigger();
        int bad, k, d2;
        bad = 0;
        trig_n = 1'b0;
        repeat (20) begin
            @(negedge clk);
            if (rst !== 1'b0) bad++;
        end
        `CHECK(bad, 0)
        trig_n = 1'b1;
        k = 0;
        while (rst !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        k = 0;
        d2 = -1;
        while (rst === 1'b1 && k < 10000) begin
            if (k == 1000) trig_n = 1'b0;
            if (k == 1500) begin
                trig_n = 1'b1;
                d2 = 0;
            end
            k++;
            if (d2 >= 0) d2++;
            @(negedge clk);
        end
        `CHECK(d2, RESET_PULSE_CYCLES + TRIG_LAT)
        $display("test_retrigger done");
    endtask

    task automatic test_slow_rates();
        window(SPAN);
        judge(0, VIDEO_HALF);
        judge(1, BAUD_HALF);
        judge(2, CPU_SLOW_HALF);
        $display("test_slow_rates done");
    endtask

    task automatic test_fast_rates();
        speed_fast = 1'b1;
        repeat (100) @(negedge clk);
        window(SPAN);
        judge(2, CPU_FAST_HALF);
        judge(0, VIDEO_HALF);
        $display("test_fast_rates done");
    endtask

    // Speed flips at ever-shifting moments; no phase may be cut short
    task automatic test_speed_switch();
        window(1);
        for (int i = 0; i < 40; i++) begin
            repeat (7 + 3 * i) @(negedge clk);
            speed_fast = ~speed_fast;
        end
        repeat (50) @(negedge clk);
        `CHECK((mn[2] * CLK_PERIOD_NS >= MIN_PHASE_NS), 1'b1)
        `CHECK((tog[2] > 32'h40), 1'b1)
        $display("test_speed_switch done");
    endtask

    task automatic test_buffers();
        for (int i = 0; i < 4; i++) begin
            {ben_n, bdir_n} = 2'(i);
            @(negedge clk);
            `CHECK({den_n, ddir_n}, 2'(i))
        end
        `CHECK(addr_bad, 0)
        $display("test_buffers done");
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        test_power_up();
        test_retrigger();
        test_slow_rates();
        test_fast_rates();
        test_speed_switch();
        test_buffers();
        final_report();
    end
endmodule
`default_nettype wire

// ---- hdl/clk_tick_div.sv ----
`timescale 1ns/1ns
`default_nettype none
module clk_tick_div
    import clk_reset_pkg::*;
#(
    parameter int unsigned HALF = 2,
    parameter int unsigned W    = 3
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic half_tick,
    output var  logic clk_out,
    output logic      toggle
);
    logic [W-1:0] count;

    // Fixed half period in ticks gives equal high and low times
    assign toggle = half_tick && (count == W'(HALF - 1));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count <= '0;
        end else if (toggle) begin
            count <= '0;
        end else if (half_tick) begin
            count <= count + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clk_out <= 1'b0;
        end else if (toggle) begin
            clk_out <= ~clk_out;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/system_clock_reset_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
module system_clock_reset_gen
    import clk_reset_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic speed_fast,
    input  wire logic reset_trigger_n,
    input  wire logic buf_enable_req_n,
    input  wire logic buf_dir_req_n,
    output var  logic video_ref_clock,
    output var  logic serial_baud_ref_clock,
    output var  logic cpu_clock,
    output var  logic sys_reset,
    output var  logic sys_reset_n,
    output var  logic addr_buffer_enable_n,
    output var  logic data_buffer_enable_n,
    output var  logic data_buffer_dir_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    logic [NCO_WIDTH-1:0]   nco_acc;
    logic                   half_tick;
    logic                   video_toggle;
    logic                   baud_toggle;
    logic                   speed_meta;
    logic                   speed_sync;
    logic                   speed_applied;
    logic [CPU_CNT_W-1:0]   cpu_count;
    logic [CPU_CNT_W-1:0]   cpu_half;
    logic [PHASE_CNT_W-1:0] phase_len;
    logic                   cpu_toggle;
    logic                   trig_meta;
    logic                   trig_sync;
    logic                   trig_prev;
    logic                   trig_rise;
    pulse_state_t           pulse_state;
    pulse_state_t           next_pulse_state;
    logic [PULSE_CNT_W-1:0] pulse_count;
    logic [PULSE_CNT_W-1:0] next_pulse_count;

    // Oscillator half-cycle ticks; jitter of one clk is the price of one clock
    logic [NCO_WIDTH:0] nco_sum;
    assign nco_sum   = {1'b0, nco_acc} + {1'b0, NCO_STEP};
    assign half_tick = nco_sum[NCO_WIDTH];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nco_acc <= '0;
        end else begin
            nco_acc <= nco_sum[NCO_WIDTH-1:0];
        end
    end

    // Video reference: divide by two
    clk_tick_div #(
        .HALF (VIDEO_HALF),
        .W    (2)
    ) video_div (
        .clk       (clk),
        .reset_n   (reset_n),
        .half_tick (half_tick),
        .clk_out   (video_ref_clock),
        .toggle    (video_toggle)
    );

    // Baud reference: divide by four
    clk_tick_div #(
        .HALF (BAUD_HALF),
        .W    (3)
    ) baud_div (
        .clk       (clk),
        .reset_n   (reset_n),
        .half_tick (half_tick),
        .clk_out   (serial_baud_ref_clock),
        .toggle    (baud_toggle)
    );

    // Speed pin comes from outside, so two flops first
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            speed_meta <= 1'b0;
            speed_sync <= 1'b0;
        end else begin
            speed_meta <= speed_fast;
            speed_sync <= speed_meta;
        end
    end

    // New speed only at a phase edge, so no phase is cut short
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            speed_applied <= 1'b0;
        end else if (cpu_toggle) begin
            speed_applied <= speed_sync;
        end
    end

    assign cpu_half = speed_applied ? CPU_CNT_W'(CPU_FAST_HALF)
                                    : CPU_CNT_W'(CPU_SLOW_HALF);

    // Tick jitter could make a 5-tick phase too short; hold it to the floor
    assign cpu_toggle = (cpu_count >= cpu_half)
                     && (phase_len >= PHASE_CNT_W'(MIN_PHASE_CYCLES));

    // Excess ticks carry over, so long-run high and low stay equal
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cpu_count <= '0;
        end else if (cpu_toggle) begin
            cpu_count <= cpu_count - cpu_half
                       + CPU_CNT_W'(half_tick);
        end else if (half_tick) begin
            cpu_count <= cpu_count + CPU_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_len <= PHASE_CNT_W'(1);
        end else if (cpu_toggle) begin
            phase_len <= PHASE_CNT_W'(1);
        end else if (phase_len != '1) begin
            phase_len <= phase_len + PHASE_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cpu_clock <= 1'b0;
        end else if (cpu_toggle) begin
            cpu_clock <= ~cpu_clock;
        end
    end

    // Trigger pin: two flops, then edge detect on the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= reset_trigger_n;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    // Pulse starts on release of the hold, never while it is low
    assign trig_rise = trig_sync && !trig_prev;

    always_comb begin
        next_pulse_state = pulse_state;
        next_pulse_count = pulse_count;
        case (pulse_state)
            RST_IDLE: begin
                if (trig_rise) begin
                    next_pulse_state = RST_PULSE;
                    next_pulse_count = PULSE_CNT_W'(RESET_PULSE_CYCLES);
                end
            end
            RST_PULSE: begin
                if (trig_rise) begin
                    next_pulse_count = PULSE_CNT_W'(RESET_PULSE_CYCLES);
                end else if (pulse_count == PULSE_CNT_W'(1)) begin
                    next_pulse_state = RST_IDLE;
                    next_pulse_count = '0;
                end else begin
                    next_pulse_count = pulse_count - PULSE_CNT_W'(1);
                end
            end
            default: begin
                next_pulse_state = RST_IDLE;
                next_pulse_count = '0;
            end
        endcase
    end

    // Both polarities from flops; inactive through our own reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pulse_state <= RST_IDLE;
            pulse_count <= '0;
            sys_reset   <= 1'b0;
            sys_reset_n <= 1'b1;
        end else begin
            pulse_state <= next_pulse_state;
            pulse_count <= next_pulse_count;
            sys_reset   <= (next_pulse_state == RST_PULSE);
            sys_reset_n <= (next_pulse_state != RST_PULSE);
        end
    end

    // Address buffers never switched off
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            addr_buffer_enable_n <= ADDR_BUF_ON_N;
        end else begin
            addr_buffer_enable_n <= ADDR_BUF_ON_N;
        end
    end

    // Requests are same-clock logic; one flop keeps outputs glitch free
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_buffer_enable_n <= 1'b1;
            data_buffer_dir_n    <= 1'b1;
        end else begin
            data_buffer_enable_n <= buf_enable_req_n;
            data_buffer_dir_n    <= buf_dir_req_n;
        end
    end

    // Helper counters, read only by the checks below
    logic [3:0]             video_ticks;
    logic [3:0]             baud_ticks;
    logic [4:0]             cpu_ticks;
    logic [PHASE_CNT_W-1:0] cpu_seen;
    logic [PULSE_CNT_W:0]   since_load;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            video_ticks <= '0;
            baud_ticks  <= '0;
            cpu_ticks   <= '0;
        end else begin
            video_ticks <= $changed(video_ref_clock)
                         ? 4'(half_tick) : video_ticks + 4'(half_tick);
            baud_ticks  <= $changed(serial_baud_ref_clock)
                         ? 4'(half_tick) : baud_ticks + 4'(half_tick);
            cpu_ticks   <= $changed(cpu_clock)
                         ? 5'(half_tick) : cpu_ticks + 5'(half_tick);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cpu_seen   <= PHASE_CNT_W'(1);
            since_load <= '0;
        end else begin
            if ($changed(cpu_clock)) begin
                cpu_seen <= PHASE_CNT_W'(1);
            end else if (cpu_seen != '1) begin
                cpu_seen <= cpu_seen + PHASE_CNT_W'(1);
            end
            if (trig_rise) begin
                since_load <= (PULSE_CNT_W+1)'(1);
            end else if (since_load != '1) begin
                since_load <= since_load + (PULSE_CNT_W+1)'(1);
            end
        end
    end

    video_half_a: assert property (
        video_toggle |-> video_ticks + 4'(half_tick) == 4'(VIDEO_HALF))
        else $error("video clock half period not two ticks");

    baud_half_a: assert property (
        baud_toggle |-> baud_ticks + 4'(half_tick) == 4'(BAUD_HALF))
        else $error("baud clock half period not four ticks");

    cpu_slow_a: assert property (
        cpu_toggle && !speed_applied |->
            cpu_ticks >= 5'(CPU_SLOW_HALF - 1)
            && cpu_ticks <= 5'(CPU_SLOW_HALF + 1))
        else $error("slow cpu half period out of range");

    cpu_fast_a: assert property (
        cpu_toggle && speed_applied |->
            cpu_ticks >= 5'(CPU_FAST_HALF - 2)
            && cpu_ticks <= 5'(CPU_FAST_HALF + 2))
        else $error("fast cpu half period out of range");

    // Helper lags the clock by one edge, so here it holds the whole phase
    cpu_min_phase_a: assert property (
        $changed(cpu_clock) |->
            cpu_seen >= PHASE_CNT_W'(MIN_PHASE_CYCLES))
        else $error("cpu clock phase shorter than minimum");

    speed_edge_a: assert property (
        $changed(speed_applied) |-> $changed(cpu_clock))
        else $error("speed changed inside a cpu clock phase");

    pulse_width_a: assert property (
        $fell(sys_reset) |->
            since_load == (PULSE_CNT_W+1)'(RESET_PULSE_CYCLES + 1))
        else $error("reset pulse width wrong");

    pulse_retrig_a: assert property (
        trig_rise && sys_reset |=> sys_reset [*8])
        else $error("retrigger did not extend reset pulse");

    reset_pair_a: assert property (
        sys_reset_n == !sys_reset)
        else $error("reset polarities disagree");

    pulse_cause_a: assert property (
        $rose(sys_reset) |-> $past(trig_rise) && $past(trig_sync, 3) == 1'b0)
        else $error("reset pulse without trigger release");

    addr_on_a: assert property (
        ##1 addr_buffer_enable_n == 1'b0)
        else $error("address buffers disabled");

    data_buf_a: assert property (
        ##1 data_buffer_enable_n == $past(buf_enable_req_n)
            && data_buffer_dir_n == $past(buf_dir_req_n))
        else $error("data buffer controls do not follow requests");
endmodule
`default_nettype wire

// ---- pkg/clk_reset_pkg.sv ----
// Summary of operation
// - Video reference clock is the master oscillator divided by two.
// - Serial baud reference clock is the master oscillator divided by four.
// - Speed select low: processor clock is master oscillator divided by ten.
// - Speed select high: processor clock is master oscillator divided by five.
// - Every divided clock has equal high and low durations.
// - No processor clock phase shorter than 110 ns, even at speed change.
// - After the power-up hold ends, issue a reset pulse of about 70 us.
// - Reset pulse is retriggerable; a new trigger restarts the full width.
// - Reset stays inactive until power is stable; drive both reset polarities.
// - Trigger held low while switch pressed; release fires a fresh pulse.
// - Processor address buffers are permanently enabled.
// - Data buffer enable and direction follow the enable and direction requests.
package clk_reset_pkg;
    localparam int unsigned CLK_HZ          = 50000000;
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned MASTER_OSC_HZ   = 20275200;

    // Oscillator is synthesised at twice its rate so that /5 stays symmetric
    localparam int unsigned NCO_WIDTH       = 24;
    localparam logic [63:0] NCO_STEP_WIDE   =
        ((64'(MASTER_OSC_HZ) * 64'h2) << NCO_WIDTH) / 64'(CLK_HZ);
    localparam logic [NCO_WIDTH-1:0] NCO_STEP = NCO_STEP_WIDE[NCO_WIDTH-1:0];

    // Half periods counted in oscillator half cycles
    localparam int unsigned VIDEO_HALF      = 2;
    localparam int unsigned BAUD_HALF       = 4;
    localparam int unsigned CPU_SLOW_HALF   = 10;
    localparam int unsigned CPU_FAST_HALF   = 5;
    localparam int unsigned CPU_CNT_W       = 5;

    localparam int unsigned MIN_PHASE_NS    = 110;
    localparam int unsigned MIN_PHASE_CYCLES =
        (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PHASE_CNT_W     = 4;

    localparam int unsigned RESET_PULSE_US  = 70;
    localparam int unsigned RESET_PULSE_CYCLES =
        (RESET_PULSE_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_CNT_W     = 12;

    localparam logic ADDR_BUF_ON_N          = 1'b0;

    typedef enum logic [1:0] {
        RST_IDLE  = 2'b00,
        RST_PULSE = 2'b01
    } pulse_state_t;
endpackage
